// ### core/pulse_train_defs.svh
// Constants for the pulse train generator: offsets, fields, resets, timing
`ifndef PULSE_TRAIN_DEFS_SVH
`define PULSE_TRAIN_DEFS_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_RATE        8'h04
`define REG_WIDTH       8'h08
`define REG_LIMIT       8'h0c
`define REG_SCALE       8'h10
`define REG_STATUS      8'h14
`define REG_COUNT       8'h18

// Control field positions
`define CTRL_MAN_EN     0
`define CTRL_START      1
`define CTRL_STOP       2
`define CTRL_MODE_LO    3
`define CTRL_RATE_FREQ  5
`define CTRL_WIDTH_LO   6
`define CTRL_FLOAT_EN   8
`define CTRL_EVT_EN     9
`define CTRL_CONT_EN    10

// Reset values
`define RATE_RESET      32'h0000_0064
`define WIDTH_RESET     32'h0000_0032
`define LIMIT_RESET     32'h0000_000a
`define SCALE_RESET     32'h3f80_0000

// Clock rate in Hz, used to turn frequency into samples
`define CLK_HZ          50000000
// Bounds fixed at configuration
`define RATE_MIN        32'h0000_0002
`define RATE_MAX        32'h0100_0000
`define WIDTH_MIN       32'h0000_0001
`define LIMIT_MIN       32'h0000_0001
`define LIMIT_MAX       32'h0100_0000
`define PCT_FULL        32'h0000_0064

`endif

// ### core/pulse_train_pkg.sv
// Types for the pulse train generator
package pulse_train_pkg;
    typedef enum logic [1:0] {
        LIMIT_NONE,
        duration_limited_mode,
        LIMIT_COUNT,
        LIMIT_RSVD
    } limit_mode_e;

    typedef enum logic [1:0] {
        WIDTH_PCT,
        WIDTH_SAMPLES,
        WIDTH_MIN_ONE,
        WIDTH_RSVD
    } width_mode_e;

    typedef struct packed {
        logic        pulse;
        logic        onset;
        logic        offset;
    } pulse_evt_s;
endpackage

// ### core/pulse_bound_calc.sv
// Turns rate and width settings into bounded sample counts
`timescale 1ns/10ps
`include "pulse_train_defs.svh"
module pulse_bound_calc
    import pulse_train_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Settings
    input  wire logic        rate_is_freq,
    input  wire logic [31:0] rate_val,
    input  width_mode_e      width_mode,
    input  wire logic [31:0] width_val,
    input  wire logic [31:0] limit_val,
    // Bounded sample counts
    output logic      [31:0] period_q,
    output logic      [31:0] high_q,
    output logic      [31:0] limit_q
);
    logic [31:0] per_d;
    logic [63:0] pct_prod;
    logic [31:0] hi_d;
    logic [31:0] lim_d;

    // Frequency becomes samples per period, then clamped
    always_comb begin
        per_d = rate_is_freq ? ((rate_val == 32'h0) ? `RATE_MAX
                : 32'(`CLK_HZ) / rate_val) : rate_val;
        if (per_d < `RATE_MIN) begin
            per_d = `RATE_MIN;
        end else if (per_d > `RATE_MAX) begin
            per_d = `RATE_MAX;
        end
    end

    // Width as percent, samples or one sample; always below period
    always_comb begin
        pct_prod = 64'(per_d) * 64'(width_val);
        case (width_mode)
            WIDTH_PCT:     hi_d = 32'(pct_prod / 64'(`PCT_FULL));
            WIDTH_SAMPLES: hi_d = width_val;
            WIDTH_MIN_ONE: hi_d = 32'h1;
            default:       hi_d = 32'h1;
        endcase
        // Keep one low sample so onsets stay distinct
        if (hi_d < `WIDTH_MIN) begin
            hi_d = `WIDTH_MIN;
        end else if (hi_d > per_d - 32'h1) begin
            hi_d = per_d - 32'h1;
        end
    end

    // Limit clamp
    always_comb begin
        lim_d = limit_val;
        if (lim_d < `LIMIT_MIN) begin
            lim_d = `LIMIT_MIN;
        end else if (lim_d > `LIMIT_MAX) begin
            lim_d = `LIMIT_MAX;
        end
    end

    // Registered to break the divider path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_q <= `RATE_RESET;
            high_q   <= `WIDTH_MIN;
            limit_q  <= `LIMIT_RESET;
        end else begin
            period_q <= per_d;
            high_q   <= hi_d;
            limit_q  <= lim_d;
        end
    end
endmodule

// ### core/pulse_train_generator.sv
// Pulse train generator with AXI4-Lite register access
`timescale 1ns/10ps
`include "pulse_train_defs.svh"
module pulse_train_generator
    import pulse_train_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Upstream enable or trigger
    input  wire logic        enable_in,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pulse outputs
    output logic             pulse_train_out,
    output logic [31:0]      scaled_pulse_out,
    output logic             float_valid_q,
    // Capture outputs
    output logic             onset_evt_q,
    output logic             offset_evt_q,
    output logic [31:0]      stream_q
);
    // Settings
    logic [31:0] ctrl_q;
    logic [31:0] rate_q;
    logic [31:0] width_q;
    logic [31:0] limit_q;
    logic [31:0] scale_q;
    logic        start_p_q;
    logic        stop_p_q;
    // Bus state
    logic [7:0]  awaddr_q;
    logic        aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_have_q;
    logic        wr_fire;
    logic        wr_ok;
    // Core state
    logic        en_s1_q;
    logic        en_s2_q;
    logic        en_prev_q;
    logic        running_q;
    logic [31:0] phase_q;
    logic [31:0] done_q;
    logic        pulse_d;
    logic        end_train;
    logic        trig_edge;
    logic [31:0] period_c;
    logic [31:0] high_c;
    logic [31:0] limit_c;
    limit_mode_e mode;
    width_mode_e wmode;
    pulse_evt_s  evt;

    assign mode  = limit_mode_e'(ctrl_q[`CTRL_MODE_LO +: 2]);
    assign wmode = width_mode_e'(ctrl_q[`CTRL_WIDTH_LO +: 2]);

    // Settings converted and bounded in the helper
    pulse_bound_calc u_calc (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .rate_is_freq (ctrl_q[`CTRL_RATE_FREQ]),
        .rate_val     (rate_q),
        .width_mode   (wmode),
        .width_val    (width_q),
        .limit_val    (limit_q),
        .period_q     (period_c),
        .high_q       (high_c),
        .limit_q      (limit_c)
    );

    // Write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_fire       = aw_have_q && w_have_q;
    assign wr_ok = (awaddr_q[1:0] == 2'b00) && (awaddr_q <= `REG_SCALE);

    // Write response, SLVERR for unmapped or read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Settings registers; start and stop are self-clearing pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= 32'h0;
            rate_q    <= `RATE_RESET;
            width_q   <= `WIDTH_RESET;
            limit_q   <= `LIMIT_RESET;
            scale_q   <= `SCALE_RESET;
            start_p_q <= 1'b0;
            stop_p_q  <= 1'b0;
        end else begin
            start_p_q <= 1'b0;
            stop_p_q  <= 1'b0;
            if (wr_fire && wr_ok) begin
                case (awaddr_q)
                    `REG_CTRL: begin
                        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_07f9;
                        start_p_q <= wstrb_q[0] & wdata_q[`CTRL_START];
                        stop_p_q  <= wstrb_q[0] & wdata_q[`CTRL_STOP];
                    end
                    `REG_RATE:  rate_q  <= merge(rate_q, wdata_q, wstrb_q);
                    `REG_WIDTH: width_q <= merge(width_q, wdata_q, wstrb_q);
                    `REG_LIMIT: limit_q <= merge(limit_q, wdata_q, wstrb_q);
                    `REG_SCALE: scale_q <= merge(scale_q, wdata_q, wstrb_q);
                    default: ;
                endcase
            end
        end
    end

    // Read channel, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                `REG_CTRL:   s_axi_rdata <= ctrl_q;
                `REG_RATE:   s_axi_rdata <= rate_q;
                `REG_WIDTH:  s_axi_rdata <= width_q;
                `REG_LIMIT:  s_axi_rdata <= limit_q;
                `REG_SCALE:  s_axi_rdata <= scale_q;
                `REG_STATUS: s_axi_rdata <= {29'h0, en_s2_q, pulse_train_out, running_q};
                `REG_COUNT:  s_axi_rdata <= done_q;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // Enable pin comes from outside; two flops first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_s1_q   <= 1'b0;
            en_s2_q   <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            en_s1_q   <= enable_in;
            en_s2_q   <= en_s1_q;
            en_prev_q <= en_s2_q;
        end
    end

    // In limited modes only a rising edge triggers; manual start acts likewise
    assign trig_edge = (en_s2_q && !en_prev_q) || start_p_q;

    // Train ends on duration or count, or by stop
    always_comb begin
        case (mode)
            duration_limited_mode: end_train = (done_q >= limit_c - 32'h1);
            LIMIT_COUNT: end_train = (phase_q == period_c - 32'h1)
                                     && (done_q >= limit_c - 32'h1);
            default: end_train = 1'b0;
        endcase
    end

    // Run state and counters; done_q counts samples or pulses by mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running_q <= 1'b0;
            phase_q   <= 32'h0;
            done_q    <= 32'h0;
        end else if (mode == LIMIT_NONE || mode == LIMIT_RSVD) begin
            running_q <= en_s2_q || ctrl_q[`CTRL_MAN_EN];
            done_q    <= 32'h0;
            if (!running_q || phase_q >= period_c - 32'h1) begin
                phase_q <= 32'h0;
            end else begin
                phase_q <= phase_q + 32'h1;
            end
        end else if (running_q) begin
            if (stop_p_q || end_train) begin
                running_q <= 1'b0;
                phase_q   <= 32'h0;
            end else begin
                if (phase_q >= period_c - 32'h1) begin
                    phase_q <= 32'h0;
                    if (mode == LIMIT_COUNT) begin
                        done_q <= done_q + 32'h1;
                    end
                end else begin
                    phase_q <= phase_q + 32'h1;
                end
                if (mode == duration_limited_mode) begin
                    done_q <= done_q + 32'h1;
                end
            end
        end else if (trig_edge && !stop_p_q) begin
            running_q <= 1'b1;
            phase_q   <= 32'h0;
            done_q    <= 32'h0;
        end
    end

    // High from onset for the width, low for the rest
    assign pulse_d = running_q && (phase_q < high_c);

    // Next pulse level and the edges it makes against the registered level
    always_comb begin
        evt.pulse  = pulse_d;
        evt.onset  = pulse_d && !pulse_train_out;
        evt.offset = !pulse_d && pulse_train_out;
    end

    // Pulse, event flags and scaled copy all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_train_out  <= 1'b0;
            onset_evt_q      <= 1'b0;
            offset_evt_q     <= 1'b0;
            scaled_pulse_out <= 32'h0;
            float_valid_q    <= 1'b0;
            stream_q         <= 32'h0;
        end else begin
            pulse_train_out <= evt.pulse;
            onset_evt_q  <= ctrl_q[`CTRL_EVT_EN] && evt.onset;
            offset_evt_q <= ctrl_q[`CTRL_EVT_EN] && evt.offset;
            float_valid_q <= ctrl_q[`CTRL_FLOAT_EN];
            // Pulse is 0 or 1, so the product is zero or the scale itself
            scaled_pulse_out <= (ctrl_q[`CTRL_FLOAT_EN] && evt.pulse) ? scale_q : 32'h0;
            if (!ctrl_q[`CTRL_CONT_EN]) begin
                stream_q <= 32'h0;
            end else if (ctrl_q[`CTRL_FLOAT_EN]) begin
                stream_q <= evt.pulse ? scale_q : 32'h0;
            end else begin
                stream_q <= {31'h0, evt.pulse};
            end
        end
    end
endmodule

// ### verif/pulse_train_generator_assertions.sv
// Port-level assertions for the pulse train generator
`timescale 1ns/10ps
module pulse_train_generator_assertions (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pulse and capture outputs
    input wire logic        pulse_train_out,
    input wire logic [31:0] scaled_pulse_out,
    input wire logic        float_valid_q,
    input wire logic        onset_evt_q,
    input wire logic        offset_evt_q,
    input wire logic [31:0] stream_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Event flags must coincide with the edges they mark
    a_onset_flag: assert property (onset_evt_q |-> $rose(pulse_train_out))
        else $error("onset flag without a rising pulse");
    a_offset_flag: assert property (offset_evt_q |-> $fell(pulse_train_out))
        else $error("offset flag without a falling pulse");
    a_scaled_low: assert property (!pulse_train_out |-> scaled_pulse_out == 32'h0)
        else $error("scaled output not zero while pulse low");
    // Past term also needs the float enable copy low a cycle earlier; the copy and stream_q register together
    a_stream_plain: assert property (!float_valid_q && $past(float_valid_q) == 1'b0
        |-> stream_q[31:1] == 31'h0)
        else $error("stream carries more than the logic train");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule

bind pulse_train_generator pulse_train_generator_assertions chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pulse_train_out(pulse_train_out), .scaled_pulse_out(scaled_pulse_out),
    .float_valid_q(float_valid_q), .onset_evt_q(onset_evt_q),
    .offset_evt_q(offset_evt_q), .stream_q(stream_q)
);

// ### verif/upstream_logic_model.sv
// Upstream source of the enable or trigger level
`timescale 1ns/10ps
module upstream_logic_model (
    // Clock
    input  wire logic aclk,
    // Level requested by the bench
    input  wire logic trig_req,
    // Level into the generator
    output logic      enable_in
);
    // Clocked source, so the level only moves just after an edge
    always @(posedge aclk) begin
        enable_in <= trig_req;
    end
endmodule

// ### verif/pulse_train_generator_tb.sv
// Self-checking bench for the pulse train generator
`timescale 1ns/10ps
`include "pulse_train_defs.svh"
module pulse_train_generator_tb import pulse_train_pkg::*; ;
    logic        aclk = 1'b0, aresetn = 1'b0, trig_req = 1'b0, enable_in;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, scaled, stream;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic        awr, wr, bv, arr, rv, pt, fv, on_e, off_e;
    logic [1:0]  bresp, rresp;
    int          fails = 0, tests_run = 0, cyc = 0;

    pulse_train_generator pulse_train_generator_inst (.aclk(aclk), .aresetn(aresetn),
        .enable_in(enable_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .pulse_train_out(pt), .scaled_pulse_out(scaled), .float_valid_q(fv),
        .onset_evt_q(on_e), .offset_evt_q(off_e), .stream_q(stream));
    upstream_logic_model upstream_logic_model_inst (.aclk(aclk), .trig_req(trig_req),
        .enable_in(enable_in));

    // 50 MHz clock and a hang guard sized well above the whole run
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus write: address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awv && awr === 1'b1) awv <= 1'b0;
            if (wv && wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 50);
        bready <= 1'b0;
        check32({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arv && arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 50);
        rready <= 1'b0;
        check32(rdata, ed);
        check32({30'h0, rresp}, {30'h0, er});
    endtask

    function automatic logic [31:0] cw(input int man, md, fr, wm, fl, ev, ct);
        return 32'((man << `CTRL_MAN_EN) | (md << `CTRL_MODE_LO) | (fr << `CTRL_RATE_FREQ)
            | (wm << `CTRL_WIDTH_LO) | (fl << `CTRL_FLOAT_EN) | (ev << `CTRL_EVT_EN)
            | (ct << `CTRL_CONT_EN));
    endfunction

    // Pulse is registered, so the falling edge sees a settled level
    task automatic shape(input int eh, input int ep);
        int n = 0, h = 0, p = 0;
        while (pt !== 1'b0 && n < 300) begin @(negedge aclk); n++; end
        while (pt !== 1'b1 && n < 300) begin @(negedge aclk); n++; end
        while (pt === 1'b1 && h < 300) begin @(negedge aclk); h++; end
        p = h;
        while (pt === 1'b0 && p < 300) begin @(negedge aclk); p++; end
        check32(32'(h), 32'(eh));
        check32(32'(p), 32'(ep));
    endtask

    task automatic rises(input int cycles, output int r);
        logic last;
        r = 0;
        last = pt;
        repeat (cycles) begin
            @(negedge aclk);
            if (pt === 1'b1 && last !== 1'b1) r++;
            last = pt;
        end
    endtask

    task automatic set_shape(input logic [31:0] rt, wd, c);
        axi_wr(`REG_RATE, rt, 2'b00);
        axi_wr(`REG_WIDTH, wd, 2'b00);
        axi_wr(`REG_CTRL, c, 2'b00);
    endtask

    // Reset values, an unmapped read and a write to a read-only place
    task automatic s_regs();
        logic [7:0]  ad [5] = '{`REG_CTRL, `REG_RATE, `REG_WIDTH, `REG_LIMIT, `REG_SCALE};
        logic [31:0] rv5 [5] = '{32'h0, `RATE_RESET, `WIDTH_RESET, `LIMIT_RESET, `SCALE_RESET};
        foreach (ad[i]) axi_rd(ad[i], rv5[i], 2'b00);
        axi_rd(8'h1c, 32'h0, 2'b10);
        axi_wr(`REG_STATUS, 32'hffff_ffff, 2'b10);
    endtask

    // Free-running shapes: samples, frequency, percent, minimum, clamping
    task automatic s_free();
        int r;
        set_shape(32'h6, 32'h2, cw(1, 0, 0, int'(WIDTH_SAMPLES), 0, 0, 0));
        shape(2, 6);
        axi_wr(`REG_CTRL, cw(0, 0, 0, int'(WIDTH_SAMPLES), 0, 0, 0), 2'b00);
        repeat (6) @(negedge aclk);
        rises(30, r);
        check32(32'(r), 32'h0);
        @(posedge aclk) trig_req <= 1'b1;
        shape(2, 6);
        @(posedge aclk) trig_req <= 1'b0;
        set_shape(32'h00be_bc20, 32'h32, cw(1, 0, 1, int'(WIDTH_PCT), 0, 0, 0));
        shape(2, 4);
        set_shape(32'h5, 32'h3, cw(1, 0, 0, int'(WIDTH_MIN_ONE), 0, 0, 0));
        shape(1, 5);
        set_shape(32'h0, 32'h9, cw(1, 0, 0, int'(WIDTH_SAMPLES), 0, 0, 0));
        shape(1, 2);
    endtask

    // Limited trains: count, held level, duration, early stop
    task automatic s_limits();
        int r;
        logic [31:0] c;
        // Drop the free-running train first, so no train is left running
        axi_wr(`REG_CTRL, 32'h0, 2'b00);
        repeat (4) @(negedge aclk);
        c = cw(0, int'(LIMIT_COUNT), 0, int'(WIDTH_SAMPLES), 0, 0, 0);
        axi_wr(`REG_LIMIT, 32'h2, 2'b00);
        set_shape(32'h4, 32'h1, c);
        @(posedge aclk) trig_req <= 1'b1;
        rises(40, r);
        check32(32'(r), 32'h2);
        rises(30, r);
        check32(32'(r), 32'h0);
        @(posedge aclk) trig_req <= 1'b0;
        axi_wr(`REG_LIMIT, 32'd20, 2'b00);
        c = cw(0, int'(duration_limited_mode), 0, int'(WIDTH_SAMPLES), 0, 0, 0);
        axi_wr(`REG_CTRL, c | (32'h1 << `CTRL_START), 2'b00);
        rises(60, r);
        check32(32'(r), 32'h5);
        axi_wr(`REG_LIMIT, 32'd100, 2'b00);
        c = cw(0, int'(LIMIT_COUNT), 0, int'(WIDTH_SAMPLES), 0, 0, 0);
        axi_wr(`REG_CTRL, c, 2'b00);
        @(posedge aclk) trig_req <= 1'b1;
        rises(16, r);
        check32(32'(r != 0), 32'h1);
        axi_wr(`REG_CTRL, c | (32'h1 << `CTRL_STOP), 2'b00);
        repeat (3) @(negedge aclk);
        rises(40, r);
        check32(32'(r), 32'h0);
        @(posedge aclk) trig_req <= 1'b0;
    endtask

    // Scaled output, event flags and the captured stream
    task automatic s_float();
        int r = 0, e = 0;
        axi_wr(`REG_SCALE, 32'h4040_0000, 2'b00);
        set_shape(32'h5, 32'h2, cw(1, 0, 0, int'(WIDTH_SAMPLES), 1, 1, 1));
        repeat (6) @(negedge aclk);
        check32({31'h0, fv}, 32'h1);
        repeat (20) begin
            @(negedge aclk);
            check32(scaled, pt ? 32'h4040_0000 : 32'h0);
            check32(stream, pt ? 32'h4040_0000 : 32'h0);
            r += int'(on_e === 1'b1);
            e += int'(off_e === 1'b1);
        end
        check32(32'(r), 32'h4);
        check32(32'(e), 32'h4);
        axi_wr(`REG_CTRL, cw(1, 0, 0, int'(WIDTH_SAMPLES), 0, 0, 1), 2'b00);
        repeat (4) @(negedge aclk);
        repeat (10) begin
            @(negedge aclk);
            check32(stream, {31'h0, pt});
        end
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_free();
        s_limits();
        s_float();
        give_verdict();
    end
endmodule
